//--- tfm_pkg.sv
/*
 Package for the trip fault memory and lamp controller: register map,
 field layout, reset values, thresholds and shared types.
 Assumes a single 100 MHz clock domain and an APB slave for software access.
*/
// Operation
// R01: First detection stores pending code and snapshot.
// R02: Second consecutive detection confirms code, lamp on.
// R03: Lamp off when B counter reaches 3.
// R04: Any malfunction clears B counter.
// R05: Clean B-pattern trip increments B counter.
// R06: Monitors flag B only after full checks.
// R07: Other category: A counter clear/increment.
// R08: Other category: hide confirmed at A=40.
// R09: Misfire/fuel: C counter clear/increment.
// R10: Misfire/fuel: hide confirmed at C=80.
// R11: C condition needs speed, load, temp together.
// R12: Speed within 375 rpm of snapshot.
// R13: Load within snapshot times one plus/minus 0.1.
// R14: Coolant same side of 70 C as snapshot.
// R15: Misfire/fuel: C count clears pending after confirm.
// R16: Other: clean B trip clears pending.
// R17: Misfire/fuel: pass result clears pending immediately.
// R18: Second detection discards pending snapshot.
// R19: Aged confirmed code stays in memory.
// R20: Second-trip pass hides pending code.
// R21: Expose qualifying drive count to tool.
// R22: Code 0000 means nothing stored.
// R23: Evaluate everything once per trip boundary.
package tfm_pkg;
    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_PEND_CODE = 8'h08;
    localparam logic [7:0] ADDR_CONF_CODE = 8'h0c;
    localparam logic [7:0] ADDR_PEND_SNAP = 8'h10;
    localparam logic [7:0] ADDR_CONF_SNAP = 8'h14;
    localparam logic [7:0] ADDR_COUNTERS  = 8'h18;
    localparam logic [7:0] ADDR_DRIVES    = 8'h1c;
    localparam logic [7:0] ADDR_RAW_CONF  = 8'h20;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_ERASE_BIT    = 0;
    localparam int CTRL_LAMP_TEST    = 1;
    localparam int ST_LAMP_BIT       = 0;
    localparam int ST_PEND_BIT       = 1;
    localparam int ST_CONF_BIT       = 2;
    localparam int ST_AGED_BIT       = 3;
    localparam int ST_MISF_BIT       = 4;
    localparam int ST_CCOND_BIT      = 5;
    localparam int CNT_A_LSB         = 0;
    localparam int CNT_B_LSB         = 8;
    localparam int CNT_C_LSB         = 16;
    // ----------------------------------------------------------------
    // Reset values and thresholds
    // ----------------------------------------------------------------
    localparam logic [15:0] NO_CODE      = 16'h0000;
    localparam logic [1:0]  B_LAMP_OFF   = 2'h3;
    localparam logic [6:0]  A_AGE_LIMIT  = 7'h28;
    localparam logic [6:0]  C_AGE_LIMIT  = 7'h50;
    localparam logic [15:0] RPM_WINDOW   = 16'h0177;
    localparam logic [7:0]  TEMP_SPLIT_C = 8'h46;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Operating snapshot: rpm, load in tenth percent, coolant in deg C
    typedef struct packed {
        logic [15:0] rpm;
        logic [9:0]  load;
        logic [7:0]  temp;
    } tfm_snap_t;

    // One trip result reported at the trip boundary
    typedef struct packed {
        logic        trip_end;
        logic        fault;
        logic        pass;
        logic        misfire_cat;
        logic        pattern_a;
        logic        pattern_b;
        logic [15:0] code;
    } tfm_trip_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EVAL = 3'b010,
        ST_DONE = 3'b100
    } tfm_state_t;
endpackage

//--- tfm_ccond.sv
/*
 Pattern C condition check: compares live operating data with a snapshot.
 Assumes inputs stable in the clock domain; result is combinational.
*/
`timescale 1ns/1ps
module tfm_ccond (
    // Live and stored operating data
    input  wire tfm_pkg::tfm_snap_t live,
    input  wire tfm_pkg::tfm_snap_t snap,
    // Result
    output wire logic               met
);
    wire logic [16:0] rpm_lo;
    wire logic [16:0] rpm_hi;
    wire logic [13:0] load_x10;
    wire logic [13:0] load_lo;
    wire logic [13:0] load_hi;
    wire logic        rpm_ok;
    wire logic        load_ok;
    wire logic        temp_ok;

    assign rpm_lo   = {1'b0, snap.rpm} - {1'b0, tfm_pkg::RPM_WINDOW};            // R12
    assign rpm_hi   = {1'b0, snap.rpm} + {1'b0, tfm_pkg::RPM_WINDOW};            // R12
    assign rpm_ok   = ({1'b0, live.rpm} <= rpm_hi) &&
                      ((snap.rpm < tfm_pkg::RPM_WINDOW) || ({1'b0, live.rpm} >= rpm_lo));
    // Scale by ten so the 10 percent band stays exact
    assign load_x10 = {4'h0, live.load} * 14'h000a;
    assign load_lo  = {4'h0, snap.load} * 14'h0009;                               // R13
    assign load_hi  = {4'h0, snap.load} * 14'h000b;                               // R13
    assign load_ok  = (load_x10 >= load_lo) && (load_x10 <= load_hi);
    assign temp_ok  = (live.temp >= tfm_pkg::TEMP_SPLIT_C) ==
                      (snap.temp >= tfm_pkg::TEMP_SPLIT_C);                       // R14
    assign met      = rpm_ok && load_ok && temp_ok;                               // R11
endmodule

//--- tfm_apb.sv
/*
 APB slave front end: decodes the register map and forms read data.
 Assumes zero wait states; pready is always high and pslverr flags
 unmapped addresses.
*/
`timescale 1ns/1ps
module tfm_apb (
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    output wire logic        pready,
    output wire logic        pslverr,
    // Register strobes and readback
    output wire logic        ctrl_wr,
    input  wire logic [31:0] rd_status,
    input  wire logic [31:0] rd_pend_code,
    input  wire logic [31:0] rd_conf_code,
    input  wire logic [31:0] rd_pend_snap,
    input  wire logic [31:0] rd_conf_snap,
    input  wire logic [31:0] rd_counters,
    input  wire logic [31:0] rd_drives,
    input  wire logic [31:0] rd_raw_conf,
    input  wire logic [31:0] rd_ctrl,
    output wire logic [31:0] rd_mux
);
    wire logic access;
    wire logic mapped;

    assign access  = psel && penable;
    assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= tfm_pkg::ADDR_RAW_CONF);
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign ctrl_wr = access && pwrite && (paddr == tfm_pkg::ADDR_CTRL);
    assign rd_mux  = (paddr == tfm_pkg::ADDR_CTRL)      ? rd_ctrl      :
                     (paddr == tfm_pkg::ADDR_STATUS)    ? rd_status    :
                     (paddr == tfm_pkg::ADDR_PEND_CODE) ? rd_pend_code :
                     (paddr == tfm_pkg::ADDR_CONF_CODE) ? rd_conf_code :
                     (paddr == tfm_pkg::ADDR_PEND_SNAP) ? rd_pend_snap :
                     (paddr == tfm_pkg::ADDR_CONF_SNAP) ? rd_conf_snap :
                     (paddr == tfm_pkg::ADDR_COUNTERS)  ? rd_counters  :
                     (paddr == tfm_pkg::ADDR_DRIVES)    ? rd_drives    :
                     (paddr == tfm_pkg::ADDR_RAW_CONF)  ? rd_raw_conf  :
                                                          tfm_pkg::RST_WORD;
endmodule

//--- tfm_top.sv
/*
 Trip fault memory and fault indicator lamp controller.
 Holds one pending and one confirmed trouble code with snapshots, runs
 the A, B and C qualification counters and drives the lamp.
 Assumes monitors present one trip result per trip_end pulse, with live
 operating data valid in the same cycle; software uses APB.
*/
`timescale 1ns/1ps
module tfm_top (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output wire logic               pready,
    output wire logic               pslverr,
    // Trip results from monitors
    input  wire tfm_pkg::tfm_trip_t trip,
    input  wire tfm_pkg::tfm_snap_t live,
    // Outputs
    output logic                    fault_indicator_lamp,
    output logic      [15:0]        pending_trouble_code,
    output logic      [15:0]        confirmed_trouble_code,
    output logic      [7:0]         drive_count
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    tfm_pkg::tfm_state_t state_q, state_d;
    tfm_pkg::tfm_trip_t  trip_q;
    tfm_pkg::tfm_snap_t  live_q;
    tfm_pkg::tfm_snap_t  pend_snap_q;
    tfm_pkg::tfm_snap_t  conf_snap_q;
    logic [15:0]         pend_code_q;
    logic [15:0]         conf_code_q;
    logic                pend_valid_q;
    logic                conf_valid_q;
    logic                conf_misf_q;
    logic                lamp_q;
    logic                lamp_test_q;
    logic [6:0]          cnt_a_q;
    logic [1:0]          cnt_b_q;
    logic [6:0]          cnt_c_q;
    logic                c_counted_q;

    // ----------------------------------------------------------------
    // Decode of the latched trip result
    // ----------------------------------------------------------------
    wire logic          c_met;
    wire logic          same_pend;
    wire logic          same_conf;
    wire logic          conf_fault;
    wire logic          first_det;
    wire logic          second_det;
    wire logic          clean_b;
    wire logic          a_step;
    wire logic          c_step;
    wire logic          a_aged;
    wire logic          c_aged;
    wire logic          conf_aged;
    wire logic          ctrl_wr;
    wire logic          do_eval;
    wire logic [31:0]   rd_mux;

    tfm_ccond u_ccond (
        .live (live_q),
        .snap (conf_valid_q ? conf_snap_q : pend_snap_q),
        .met  (c_met)
    );

    assign do_eval    = (state_q == tfm_pkg::ST_EVAL);                          // R23
    assign same_pend  = pend_valid_q && (trip_q.code == pend_code_q);
    assign same_conf  = conf_valid_q && (trip_q.code == conf_code_q);
    assign first_det  = trip_q.fault && !same_pend && !same_conf;               // R01
    assign second_det = trip_q.fault && same_pend;                              // R02
    assign clean_b    = trip_q.pattern_b && !trip_q.fault;                      // R05 R06
    assign conf_fault = trip_q.fault && same_conf;
    assign a_step     = conf_valid_q && !conf_misf_q && trip_q.pattern_a && !conf_fault; // R07
    assign c_step     = conf_misf_q && c_met && !conf_fault;                    // R09
    assign a_aged     = !conf_misf_q && (cnt_a_q >= tfm_pkg::A_AGE_LIMIT);      // R08
    assign c_aged     = conf_misf_q && (cnt_c_q >= tfm_pkg::C_AGE_LIMIT);       // R10
    assign conf_aged  = conf_valid_q && (a_aged || c_aged);

    // ----------------------------------------------------------------
    // Trip boundary sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            tfm_pkg::ST_IDLE: begin
                if (trip.trip_end) begin
                    state_d = tfm_pkg::ST_EVAL;
                end
            end
            tfm_pkg::ST_EVAL: begin
                state_d = tfm_pkg::ST_DONE;
            end
            tfm_pkg::ST_DONE: begin
                state_d = tfm_pkg::ST_IDLE;
            end
            default: begin
                state_d = tfm_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= tfm_pkg::ST_IDLE;
            trip_q  <= '0;
            live_q  <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == tfm_pkg::ST_IDLE && trip.trip_end) begin
                trip_q <= trip;
                live_q <= live;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pending code and snapshot
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n || (ctrl_wr && pwdata[tfm_pkg::CTRL_ERASE_BIT]
                       && !(do_eval && first_det))) begin
            pend_valid_q <= 1'b0;
            pend_code_q  <= tfm_pkg::NO_CODE;
            pend_snap_q  <= '0;
        end else if (do_eval) begin
            if (first_det) begin
                pend_valid_q <= 1'b1;                                           // R01
                pend_code_q  <= trip_q.code;
                pend_snap_q  <= live_q;
            end else if (second_det) begin
                pend_snap_q  <= '0;                                             // R18
            end else if (pend_valid_q && trip_q.misfire_cat && trip_q.pass) begin
                pend_valid_q <= 1'b0;                                           // R17 R20
                pend_code_q  <= tfm_pkg::NO_CODE;
                pend_snap_q  <= '0;
            end else if (pend_valid_q && conf_valid_q && conf_misf_q && c_step
                         && (pend_code_q == conf_code_q)) begin
                pend_valid_q <= 1'b0;                                           // R15
                pend_code_q  <= tfm_pkg::NO_CODE;
            end else if (pend_valid_q && !trip_q.misfire_cat && trip_q.pattern_b
                         && !(trip_q.fault && trip_q.code == pend_code_q)) begin
                pend_valid_q <= 1'b0;                                           // R16
                pend_code_q  <= tfm_pkg::NO_CODE;
                pend_snap_q  <= '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Confirmed code, snapshot and category
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n || (ctrl_wr && pwdata[tfm_pkg::CTRL_ERASE_BIT]
                       && !(do_eval && second_det))) begin
            conf_valid_q <= 1'b0;
            conf_code_q  <= tfm_pkg::NO_CODE;
            conf_snap_q  <= '0;
            conf_misf_q  <= 1'b0;
        end else if (do_eval && second_det) begin
            conf_valid_q <= 1'b1;                                               // R02
            conf_code_q  <= trip_q.code;
            conf_snap_q  <= live_q;
            conf_misf_q  <= trip_q.misfire_cat;
        end
    end

    // ----------------------------------------------------------------
    // Qualification counters
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n || (ctrl_wr && pwdata[tfm_pkg::CTRL_ERASE_BIT])) begin
            cnt_a_q     <= '0;
            cnt_b_q     <= '0;
            cnt_c_q     <= '0;
            c_counted_q <= 1'b0;
        end else if (do_eval) begin
            if (trip_q.fault) begin
                cnt_b_q <= '0;                                                  // R04
            end else if (clean_b && cnt_b_q != tfm_pkg::B_LAMP_OFF) begin
                cnt_b_q <= cnt_b_q + 2'h1;                                      // R05
            end
            if (second_det || conf_fault) begin
                cnt_a_q <= '0;                                                  // R07
                cnt_c_q <= '0;                                                  // R09
            end else begin
                if (a_step && cnt_a_q != tfm_pkg::A_AGE_LIMIT) begin
                    cnt_a_q <= cnt_a_q + 7'h01;                                 // R07
                end
                if (c_step && cnt_c_q != tfm_pkg::C_AGE_LIMIT) begin
                    cnt_c_q <= cnt_c_q + 7'h01;                                 // R09
                    c_counted_q <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Fault indicator lamp and lamp test control
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n || (ctrl_wr && pwdata[tfm_pkg::CTRL_ERASE_BIT]
                       && !(do_eval && second_det))) begin
            lamp_q <= 1'b0;
        end else if (do_eval && second_det) begin
            lamp_q <= 1'b1;                                                     // R02
        end else if (state_q == tfm_pkg::ST_DONE && cnt_b_q == tfm_pkg::B_LAMP_OFF) begin
            lamp_q <= 1'b0;                                                     // R03
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lamp_test_q <= 1'b0;
        end else if (ctrl_wr) begin
            lamp_test_q <= pwdata[tfm_pkg::CTRL_LAMP_TEST];
        end
    end

    // ----------------------------------------------------------------
    // Presented outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_indicator_lamp   <= 1'b0;
            pending_trouble_code   <= tfm_pkg::NO_CODE;
            confirmed_trouble_code <= tfm_pkg::NO_CODE;
            drive_count            <= '0;
        end else begin
            fault_indicator_lamp   <= lamp_q || lamp_test_q;
            pending_trouble_code   <= pend_valid_q ? pend_code_q : tfm_pkg::NO_CODE; // R22
            confirmed_trouble_code <= (conf_valid_q && !conf_aged) ?
                                      conf_code_q : tfm_pkg::NO_CODE;           // R08 R10 R22
            drive_count            <= {1'b0, conf_misf_q ? cnt_c_q : cnt_a_q};  // R21
        end
    end

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    tfm_apb u_apb (
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pready       (pready),
        .pslverr      (pslverr),
        .ctrl_wr      (ctrl_wr),
        .rd_ctrl      ({30'h0, lamp_test_q, 1'b0}),
        .rd_status    ({26'h0, c_met, conf_misf_q, conf_aged, conf_valid_q,
                        pend_valid_q, lamp_q}),
        .rd_pend_code ({16'h0, pending_trouble_code}),
        .rd_conf_code ({16'h0, confirmed_trouble_code}),
        .rd_pend_snap ({pend_snap_q.rpm, 6'h0, pend_snap_q.load[9:0]}),
        .rd_conf_snap ({conf_snap_q.rpm, conf_snap_q.temp, conf_snap_q.load[7:0]}),
        .rd_counters  ({8'h0, 1'b0, cnt_c_q, 6'h0, cnt_b_q, 1'b0, cnt_a_q}),
        .rd_drives    ({24'h0, drive_count}),
        .rd_raw_conf  ({15'h0, conf_valid_q, conf_code_q}),                     // R19
        .rd_mux       (rd_mux)
    );

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata <= tfm_pkg::RST_WORD;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end
endmodule

//--- tfm_mon_model.sv
/*
 Monitor-side model: presents one trip result per send call.
 Assumes tfm_top samples trip and live in the trip_end cycle only.
*/
`timescale 1ns/1ps
module tfm_mon_model (
    // Clock
    input  wire logic          mclk,
    // Trip result and live data
    output tfm_pkg::tfm_trip_t trip,
    output tfm_pkg::tfm_snap_t live
);
    initial begin
        trip = '0;
        live = '0;
    end
    // Flags are {fault, pass, misfire_cat, pattern_a, pattern_b}
    // Caller sets pattern_b only for trips whose checks all completed
    task automatic send(input logic [4:0] flags, input logic [15:0] code,
                        input tfm_pkg::tfm_snap_t l);
        trip <= {1'b1, flags, code};
        live <= l;
        @(posedge mclk);
        // Stale fields are inverted so they never look like a result
        trip <= {1'b0, ~flags, ~code};
        live <= ~l;
        repeat (5) @(posedge mclk);
    endtask
endmodule

//--- tfm_top_sva.sv
/*
 Checker for tfm_top, watching its ports only.
 Assumes the bind below; trips arrive at least 3 cycles apart.
*/
`timescale 1ns/1ps
module tfm_chk (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               rst_n,
    // APB
    input wire logic               psel,
    input wire logic               penable,
    input wire logic [7:0]         paddr,
    input wire logic               pready,
    input wire logic               pslverr,
    // Trip and outputs
    input wire tfm_pkg::tfm_trip_t trip,
    input wire logic               fault_indicator_lamp,
    input wire logic [15:0]        pending_trouble_code,
    input wire logic [15:0]        confirmed_trouble_code,
    input wire logic [7:0]         drive_count
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Cycles since the last trip or bus access
    logic [3:0] since_q;
    always_ff @(posedge mclk) begin
        if (!rst_n || trip.trip_end || psel) begin
            since_q <= 4'h0;
        end else if (since_q != 4'hf) begin
            since_q <= since_q + 4'h1;
        end
    end
    chk_reset_clear: assert property ($rose(rst_n) |-> pending_trouble_code == 16'h0000
        && confirmed_trouble_code == 16'h0000 && !fault_indicator_lamp)
        else $error("outputs not clear after reset");
    chk_first_pend: assert property (trip.trip_end && trip.fault
        && pending_trouble_code == 16'h0000 && confirmed_trouble_code == 16'h0000
        |-> ##3 pending_trouble_code == $past(trip.code, 3)) else $error("pending not stored");
    chk_confirm_lamp: assert property (trip.trip_end && trip.fault
        && pending_trouble_code == trip.code && pending_trouble_code != 16'h0000
        |-> ##3 confirmed_trouble_code == $past(trip.code, 3) && fault_indicator_lamp)
        else $error("second detection not confirmed");
    chk_fault_lamp: assert property (trip.trip_end && trip.fault ##1 fault_indicator_lamp
        |-> fault_indicator_lamp [*6]) else $error("lamp dropped after a fault");
    chk_pass_clear: assert property (trip.trip_end && trip.pass && !trip.fault
        && trip.misfire_cat && pending_trouble_code == trip.code
        |-> ##3 pending_trouble_code == 16'h0000) else $error("pass kept pending code");
    chk_out_timing: assert property (!$stable(pending_trouble_code)
        || !$stable(confirmed_trouble_code) || !$stable(drive_count)
        || !$stable(fault_indicator_lamp) |-> since_q <= 4'h3) else $error("output moved late");
    chk_count_cap: assert property (drive_count <= 8'h50)
        else $error("drive count beyond limit");
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_unmapped: assert property (psel && penable && paddr > 8'h20 |-> pslverr)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (psel && penable && paddr <= 8'h20 && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("mapped access refused");
endmodule
bind tfm_top tfm_chk u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .trip(trip),
    .fault_indicator_lamp(fault_indicator_lamp), .pending_trouble_code(pending_trouble_code),
    .confirmed_trouble_code(confirmed_trouble_code), .drive_count(drive_count));

//--- tfm_top_tb.sv
/*
 Testbench for tfm_top: APB tasks plus trip sequences from the monitor model.
 Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module tfm_top_tb;
    logic               mclk, rst_n, psel, penable, pwrite, pready, pslverr, lamp, err;
    logic [7:0]         paddr, dcnt;
    logic [31:0]        pwdata, prdata, rd;
    logic [15:0]        pcode, ccode;
    tfm_pkg::tfm_trip_t trip;
    tfm_pkg::tfm_snap_t live, lv [6];
    int                 fails = 0;
    int                 total_checks = 0;
    localparam logic [4:0] FLT = 5'h10, PAS = 5'h08, MIS = 5'h04, PA = 5'h02, PB = 5'h01;
    localparam tfm_pkg::tfm_snap_t SNAP = {16'h0352, 10'h12c, 8'h50};
    tfm_top dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trip(trip), .live(live), .fault_indicator_lamp(lamp),
        .pending_trouble_code(pcode), .confirmed_trouble_code(ccode), .drive_count(dcnt));
    tfm_mon_model mdl (.mclk(mclk), .trip(trip), .live(live));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic out(input logic l, input logic [15:0] p, input logic [15:0] c,
                       input logic [7:0] n);
        check({15'h0, lamp, pcode}, {15'h0, l, p});
        check({8'h0, dcnt, ccode}, {8'h0, n, c});
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #50us;
        fails++;
        print_verdict();
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        lv = '{{16'h04ca, 10'h12c, 8'h50}, {16'h01db, 10'h14b, 8'h50},
               {16'h0352, 10'h10d, 8'h50}, {16'h0352, 10'h12c, 8'h45},
               {16'h04c9, 10'h14a, 8'h46}, {16'h01db, 10'h10e, 8'h7f}};
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        out(1'b0, 16'h0, 16'h0, 8'h0);
        apb(1'b0, tfm_pkg::ADDR_STATUS, 32'h0);
        check(rd, 32'h0000_0020);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test reset done");
        mdl.send(FLT | PA | PB, 16'h0101, SNAP);
        out(1'b0, 16'h0101, 16'h0, 8'h0);
        mdl.send(FLT, 16'h0101, SNAP);
        out(1'b1, 16'h0101, 16'h0101, 8'h0);
        apb(1'b0, tfm_pkg::ADDR_PEND_SNAP, 32'h0);
        check(rd, 32'h0);
        mdl.send(PA | PB, 16'h0101, SNAP);
        mdl.send(PA | PB, 16'h0101, SNAP);
        check({lamp, dcnt}, {1'b1, 8'h2});
        mdl.send(FLT | PB, 16'h0101, SNAP);
        check({lamp, dcnt}, {1'b1, 8'h0});
        for (int i = 1; i <= 3; i++) begin
            mdl.send(PA | PB, 16'h0101, SNAP);
            out(i < 3, 16'h0, 16'h0101, 8'(i));
        end
        for (int i = 4; i <= 40; i++) begin
            mdl.send(PA, 16'h0101, SNAP);
            if (i >= 39) out(1'b0, 16'h0, (i < 40) ? 16'h0101 : 16'h0, 8'(i));
        end
        apb(1'b0, tfm_pkg::ADDR_RAW_CONF, 32'h0);
        check({16'h0, rd[15:0]}, 32'h0101);
        apb(1'b1, tfm_pkg::ADDR_CTRL, 32'h3);
        @(posedge mclk);
        out(1'b1, 16'h0, 16'h0, 8'h0);
        apb(1'b1, tfm_pkg::ADDR_CTRL, 32'h0);
        $display("test other category done");
        mdl.send(FLT | MIS, 16'h0300, SNAP);
        out(1'b0, 16'h0300, 16'h0, 8'h0);
        mdl.send(PAS | MIS, 16'h0300, SNAP);
        out(1'b0, 16'h0, 16'h0, 8'h0);
        mdl.send(FLT | MIS, 16'h0300, SNAP);
        mdl.send(FLT | MIS, 16'h0300, SNAP);
        out(1'b1, 16'h0300, 16'h0300, 8'h0);
        for (int i = 0; i < 6; i++) begin
            mdl.send(MIS, 16'h0300, lv[i]);
            out(1'b1, (i < 4) ? 16'h0300 : 16'h0, 16'h0300, 8'((i < 4) ? 0 : i - 3));
        end
        for (int i = 3; i <= 80; i++) begin
            mdl.send(MIS, 16'h0300, SNAP);
            if (i >= 79) out(1'b1, 16'h0, (i < 80) ? 16'h0300 : 16'h0, 8'(i));
        end
        $display("test misfire category done");
        print_verdict();
    end
endmodule
